// ===== bench/lcs_cell_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module lcs_cell_tb_top;
   logic        core_clk;
   logic        rst_n;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [3:0]  cell_control_inputs;
   logic [3:0]  f_addr_pin;
   logic [3:0]  g_addr_pin;
   logic        cell_clk;
   logic        global_preset_clear;
   logic        registered_out_x;
   logic        registered_out_y;
   logic        f_gen_out;
   logic        g_gen_out;
   logic        h_gen_out;
   int          n_fail;
   int          compares;
   int          cyc;
   logic [31:0] q;

   lcs_cell lcs_cell_i (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .cell_control_inputs(cell_control_inputs), .f_addr_pin(f_addr_pin),
      .g_addr_pin(g_addr_pin), .cell_clk(cell_clk), .global_preset_clear(global_preset_clear),
      .registered_out_x(registered_out_x), .registered_out_y(registered_out_y),
      .f_gen_out(f_gen_out), .g_gen_out(g_gen_out), .h_gen_out(h_gen_out));

   lcs_user_model lcs_user_model_i (.core_clk(core_clk),
      .cell_control_inputs(cell_control_inputs), .f_addr_pin(f_addr_pin),
      .g_addr_pin(g_addr_pin), .cell_clk(cell_clk), .global_preset_clear(global_preset_clear));

   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;

   task automatic close_out();
      $display("checks %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         close_out();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, q, exp);
   endtask

   task automatic outs(input string nm, input logic [1:0] xy);
      chk(nm, {registered_out_x, registered_out_y}, xy);
   endtask

   initial
   begin
      n_fail = 0;
      compares = 0;
      cyc = 0;
      rst_n = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      rd("cfg", lcs_pkg::OFS_CFG, lcs_pkg::CFG_RST);
      rd("map", lcs_pkg::OFS_MAP, lcs_pkg::MAP_RST);
      rd("cmd", lcs_pkg::OFS_CMD, lcs_pkg::CMD_RST);
      bus(1'b1, lcs_pkg::OFS_STAT, 32'h0000_00FF);
      rd("stat", lcs_pkg::OFS_STAT, 32'h0000_0000);
      bus(1'b1, 5'h18, 32'h1234_5678);
      rd("unmapped", 5'h18, 32'h0000_0000);
      $display("test registers done");
      // x set-valued with local force, y reset-valued without, both take direct data
      bus(1'b1, lcs_pkg::OFS_CFG, 32'h000F_0140);
      lcs_user_model_i.tick();
      lcs_user_model_i.put(4'h3, 4'h0, 4'h0);
      lcs_user_model_i.tick();
      outs("force over data", 2'h2);
      lcs_user_model_i.put(4'h5, 4'h0, 4'h0);
      lcs_user_model_i.tick();
      outs("direct data", 2'h3);
      lcs_user_model_i.put(4'h0, 4'h0, 4'h0);
      lcs_user_model_i.tick();
      outs("enable low holds", 2'h3);
      bus(1'b1, lcs_pkg::OFS_CFG, 32'h000F_0340);
      bus(1'b1, lcs_pkg::OFS_CMD, 32'h0000_0001);
      repeat (4) @(posedge core_clk);
      outs("global node", 2'h2);
      bus(1'b1, lcs_pkg::OFS_CMD, 32'h0000_0000);
      bus(1'b1, lcs_pkg::OFS_CFG, 32'h000F_3340);
      lcs_user_model_i.pin(1'b1);
      lcs_user_model_i.put(4'h5, 4'h0, 4'h0);
      lcs_user_model_i.tick();
      outs("inverted pin idle", 2'h3);
      lcs_user_model_i.pin(1'b0);
      outs("inverted pin force", 2'h2);
      lcs_user_model_i.pin(1'b1);
      $display("test storage done");
      bus(1'b1, lcs_pkg::OFS_CFG, 32'h00D0_0000);
      lcs_user_model_i.put(4'h8, 4'h0, 4'h0);
      chk("bypass high", registered_out_x, 1'b1);
      lcs_user_model_i.put(4'h0, 4'h0, 4'h0);
      chk("bypass low", registered_out_x, 1'b0);
      bus(1'b1, lcs_pkg::OFS_MAP, 32'h0000_801B);
      lcs_user_model_i.put(4'h7, 4'h0, 4'h0);
      chk("remap h one", h_gen_out, 1'b1);
      lcs_user_model_i.put(4'hE, 4'h0, 4'h0);
      chk("remap h zero", h_gen_out, 1'b0);
      bus(1'b1, lcs_pkg::OFS_MAP, lcs_pkg::MAP_RST);
      $display("test control map done");
      // split memories, separate addresses, edge writes
      bus(1'b1, lcs_pkg::OFS_CFG, 32'h0C00_0001);
      lcs_user_model_i.put(4'h6, 4'h5, 4'h9);
      lcs_user_model_i.tick();
      lcs_user_model_i.put(4'hA, 4'h5, 4'h9);
      chk("split f no tick", f_gen_out, 1'b1);
      chk("split g before", g_gen_out, 1'b0);
      lcs_user_model_i.tick();
      lcs_user_model_i.put(4'h0, 4'h5, 4'h9);
      chk("split f own data", f_gen_out, 1'b0);
      chk("split g", g_gen_out, 1'b1);
      lcs_user_model_i.put(4'h0, 4'h4, 4'h8);
      chk("split neighbours", {f_gen_out, g_gen_out}, 2'h0);
      bus(1'b1, lcs_pkg::OFS_CFG, 32'h0400_0001);
      lcs_user_model_i.put(4'hE, 4'h2, 4'h2);
      lcs_user_model_i.tick();
      chk("split f only", {f_gen_out, g_gen_out}, 2'h2);
      $display("test split done");
      bus(1'b1, lcs_pkg::OFS_CFG, 32'h0000_0003);
      lcs_user_model_i.put(4'h6, 4'h3, 4'h3);
      lcs_user_model_i.tick();
      chk("dual same addr", {f_gen_out, g_gen_out}, 2'h3);
      lcs_user_model_i.put(4'h6, 4'h8, 4'h3);
      lcs_user_model_i.tick();
      chk("dual other addr", {f_gen_out, g_gen_out}, 2'h3);
      lcs_user_model_i.put(4'h0, 4'h8, 4'h8);
      chk("dual g at write addr", g_gen_out, 1'b1);
      lcs_user_model_i.put(4'h0, 4'h8, 4'h2);
      chk("dual g idle addr", g_gen_out, 1'b0);
      bus(1'b1, lcs_pkg::OFS_CFG, 32'h0000_0007);
      lcs_user_model_i.put(4'h6, 4'h9, 4'h9);
      chk("dual ignores level", f_gen_out, 1'b0);
      $display("test dual done");
      bus(1'b1, lcs_pkg::OFS_CFG, 32'h0C00_0005);
      lcs_user_model_i.strobe(4'h4, 4'hC);
      chk("level f", f_gen_out, 1'b1);
      bus(1'b1, lcs_pkg::OFS_CFG, 32'h0000_0002);
      lcs_user_model_i.put(4'hE, 4'h6, 4'h6);
      lcs_user_model_i.tick();
      lcs_user_model_i.put(4'h8, 4'h6, 4'h6);
      chk("wide upper", f_gen_out, 1'b1);
      lcs_user_model_i.put(4'h0, 4'h6, 4'h6);
      chk("wide lower", f_gen_out, 1'b0);
      $display("test memory modes done");
      bus(1'b1, lcs_pkg::OFS_CFG, 32'h0000_0000);
      bus(1'b1, lcs_pkg::OFS_LUTF, 32'hFFFF_A5C3);
      rd("lutf", lcs_pkg::OFS_LUTF, 32'h0000_A5C3);
      for (int i = 0; i < 16; i++)
      begin
         lcs_user_model_i.put(4'h0, i[3:0], 4'h0);
         chk("lookup", f_gen_out, (16'hA5C3 >> i) & 16'h0001);
      end
      $display("test lookup done");
      close_out();
   end
endmodule
`default_nettype wire

// ===== bench/lcs_user_model.sv
`timescale 1ns/10ps
`default_nettype none
module lcs_user_model
(
   input wire logic   core_clk,
   output logic [3:0] cell_control_inputs,
   output logic [3:0] f_addr_pin,
   output logic [3:0] g_addr_pin,
   output logic       cell_clk,
   output logic       global_preset_clear
);
   initial
   begin
      cell_control_inputs = 4'h0;
      f_addr_pin          = 4'h0;
      g_addr_pin          = 4'h0;
      cell_clk            = 1'b0;
      global_preset_clear = 1'b0;
   end

   // pins pass two sync flops, so give them time to land
   task automatic put(input logic [3:0] c, input logic [3:0] fa, input logic [3:0] ga);
      @(posedge core_clk);
      cell_control_inputs <= c;
      f_addr_pin          <= fa;
      g_addr_pin          <= ga;
      repeat (6) @(posedge core_clk);
   endtask

   task automatic pin(input logic v);
      @(posedge core_clk);
      global_preset_clear <= v;
      repeat (6) @(posedge core_clk);
   endtask

   // cell clock is sampled, so each phase spans several core cycles
   task automatic tick();
      @(posedge core_clk);
      cell_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      cell_clk <= 1'b0;
      repeat (8) @(posedge core_clk);
   endtask

   // write enable held as the strobe itself, address and data steady
   task automatic strobe(input logic [3:0] c, input logic [3:0] fa);
      put(c, fa, fa);
      put(c | 4'h2, fa, fa);
      put(c, fa, fa);
   endtask
endmodule
`default_nettype wire

// ===== design/lcs_cell.sv
// Behaviour
// - one configuration bit sets power-up, global and local force value per element.
// - set/reset value and local force enable are separate for each element.
// - local set/reset input is active high, no inversion in the cell.
// - global set/reset forces all elements at power-up and when driven.
// - global and local force drive an element to the same value.
// - global source is a pin with optional inversion, or an internal node.
// - each element's data comes from F, G, H or the direct input.
// - each registered output picks element output or a control input bypass.
// - any of four control inputs may drive any internal control signal.
// - logic mode controls are enable, set/reset/H0, direct-in/H2, and H1.
// - memory mode controls are enable, write enable, first and second data.
// - lookup tables serve as 16x2, 32x1 or 16x1 memory.
// - dual-port joins both tables, one write port, always edge timed.
// - two 16x1 memories have own data and shared or separate addresses.
// - one table may be memory while others stay logic.
// - edge mode writes on the selected clock edge; enable gates it.
// - timing mode choice applies to both tables together.
// - single-port tables share one address for read and write.
// - dual-port reads and writes same cycle, equal or different addresses.
// - reads behave the same in every memory mode.
// - reads are combinational lookups with no clock.
// - active edge captures address, data and enable; a pulse then writes.
// - dual-port primary address reads first output and writes both tables.
// - clock enable active high; defaults active when left unconnected.
// - in memory mode table inputs are address lines.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module lcs_cell
(
   input wire logic         core_clk,
   input wire logic         rst_n,
   input wire logic [4:0]   avs_address,
   input wire logic         avs_read,
   input wire logic         avs_write,
   input wire logic [31:0]  avs_writedata,
   input wire logic [3:0]   avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input wire logic [3:0]   cell_control_inputs,
   input wire logic [3:0]   f_addr_pin,
   input wire logic [3:0]   g_addr_pin,
   input wire logic         cell_clk,
   input wire logic         global_preset_clear,
   output logic             registered_out_x,
   output logic             registered_out_y,
   output logic             f_gen_out,
   output logic             g_gen_out,
   output logic             h_gen_out
);
   localparam int SW = 14;

   logic [SW-1:0] sync_in;
   logic [SW-1:0] sync_a;
   logic [SW-1:0] sync_b;
   logic          k_d;
   logic          k_s;
   logic          gpin_s;
   logic [3:0]    cin_s;
   logic [3:0]    fa_s;
   logic [3:0]    ga_s;
   logic          k_rise;
   logic          k_fall;

   // every cell pin passes two flops first; the Avalon-MM bus pins do not
   assign sync_in = {cell_clk, global_preset_clear, cell_control_inputs, f_addr_pin, g_addr_pin};

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_a <= '0;
         sync_b <= '0;
         k_d    <= 1'b0;
      end
      else
      begin
         sync_a <= sync_in;
         sync_b <= sync_a;
         k_d    <= sync_b[13];
      end
   end

   assign k_s    = sync_b[13];
   assign gpin_s = sync_b[12];
   assign cin_s  = sync_b[11:8];
   assign fa_s   = sync_b[7:4];
   assign ga_s   = sync_b[3:0];
   assign k_rise = k_s & ~k_d;
   assign k_fall = ~k_s & k_d;

   // ---------------- register slave ----------------
   logic        ack;
   logic        bus_req;
   logic        bus_wr;
   logic        bus_rd;
   logic [31:0] wmask;
   logic        sel_cfg;
   logic        sel_map;
   logic        sel_cmd;
   logic        sel_lutf;
   logic        sel_lutg;
   logic        sel_stat;
   logic [31:0] cfg;
   logic [31:0] map;
   logic [31:0] cmd;
   logic [31:0] rd_mux;
   logic [31:0] status;

   assign bus_req         = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~ack;
   assign bus_wr          = avs_write & ack;
   assign bus_rd          = avs_read & ~ack;
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign sel_cfg  = avs_address == lcs_pkg::OFS_CFG;
   assign sel_map  = avs_address == lcs_pkg::OFS_MAP;
   assign sel_cmd  = avs_address == lcs_pkg::OFS_CMD;
   assign sel_lutf = avs_address == lcs_pkg::OFS_LUTF;
   assign sel_lutg = avs_address == lcs_pkg::OFS_LUTG;
   assign sel_stat = avs_address == lcs_pkg::OFS_STAT;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [31:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ack <= 1'b0;
      else
         ack <= bus_req & ~ack;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg <= lcs_pkg::CFG_RST;
         map <= lcs_pkg::MAP_RST;
         cmd <= lcs_pkg::CMD_RST;
      end
      else if (bus_wr)
      begin
         if (sel_cfg)
            cfg <= merge(cfg, avs_writedata, wmask);
         if (sel_map)
            map <= merge(map, avs_writedata, wmask);
         if (sel_cmd)
            cmd <= merge(cmd, avs_writedata, wmask);
      end
   end

   lcs_lut_if #(.AW(4)) f_if ();
   lcs_lut_if #(.AW(4)) g_if ();

   assign rd_mux = sel_cfg  ? cfg :
                   sel_map  ? map :
                   sel_cmd  ? cmd :
                   sel_lutf ? {16'h0000, f_if.contents} :
                   sel_lutg ? {16'h0000, g_if.contents} :
                   sel_stat ? status : 32'h0000_0000;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         avs_readdata <= 32'h0000_0000;
      else if (bus_rd)
         avs_readdata <= rd_mux;
   end

   // ---------------- configuration decode ----------------
   lcs_pkg::lcs_mode_t mode;
   logic       split;
   logic       wide;
   logic       dual;
   logic       memf;
   logic       memg;
   logic       mem_any;
   logic       lvl;
   logic [3:0] ctl_int;
   logic       ec;
   logic       sr_h0;
   logic       din;
   logic       h1i;

   assign mode    = lcs_pkg::lcs_mode_t'(cfg[lcs_pkg::CFG_MODE +: 2]);
   assign split   = mode == lcs_pkg::LCS_SPLIT;
   assign wide    = mode == lcs_pkg::LCS_WIDE;
   assign dual    = mode == lcs_pkg::LCS_DUAL;
   assign memf    = wide | dual | (split & cfg[lcs_pkg::CFG_MEMF]);
   assign memg    = wide | dual | (split & cfg[lcs_pkg::CFG_MEMG]);
   assign mem_any = memf | memg;
   // one timing choice for both tables; dual-port never level timed
   assign lvl     = cfg[lcs_pkg::CFG_LVL] & ~dual;

   genvar c;
   generate
      for (c = 0; c < 4; c++)
      begin : g_cmap
         assign ctl_int[c] = cin_s[map[lcs_pkg::MAP_SEL + 2*c +: 2]];
      end
   endgenerate

   assign ec    = ctl_int[lcs_pkg::CI_EC];
   assign sr_h0 = ctl_int[lcs_pkg::CI_SR];
   assign din   = ctl_int[lcs_pkg::CI_DIN];
   assign h1i   = ctl_int[lcs_pkg::CI_H1];

   // ---------------- memory write path ----------------
   logic       we;
   logic       d0;
   logic       d1;
   logic       local_sr;
   logic       wclk_edge;
   logic       we_f_now;
   logic       we_g_now;
   logic [3:0] wa_g_now;
   logic       wd_g_now;
   logic       cap_wf;
   logic       cap_wg;
   logic [3:0] cap_fa;
   logic [3:0] cap_ga;
   logic       cap_df;
   logic       cap_dg;

   assign we       = mem_any & sr_h0;
   assign d0       = din;
   assign d1       = h1i;
   assign local_sr = ~mem_any & sr_h0;
   assign wclk_edge = cfg[lcs_pkg::CFG_WFALL] ? k_fall : k_rise;
   // in 32x1 the second data line is address bit four
   assign we_f_now = we & memf & (~wide | ~d1);
   assign we_g_now = we & memg & (~wide | d1);
   assign wa_g_now = split ? ga_s : fa_s;
   assign wd_g_now = split ? d1 : d0;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cap_wf <= 1'b0;
         cap_wg <= 1'b0;
         cap_fa <= 4'h0;
         cap_ga <= 4'h0;
         cap_df <= 1'b0;
         cap_dg <= 1'b0;
      end
      else if (wclk_edge && !lvl)
      begin
         cap_wf <= we_f_now;
         cap_wg <= we_g_now;
         cap_fa <= fa_s;
         cap_ga <= wa_g_now;
         cap_df <= d0;
         cap_dg <= wd_g_now;
      end
      else
      begin
         cap_wf <= 1'b0;
         cap_wg <= 1'b0;
      end
   end

   assign f_if.wr      = lvl ? we_f_now : cap_wf;
   assign f_if.waddr   = lvl ? fa_s : cap_fa;
   assign f_if.wdata   = lvl ? d0 : cap_df;
   assign f_if.raddr   = fa_s;
   assign f_if.ld      = bus_wr & sel_lutf;
   assign f_if.ld_data = (f_if.contents & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
   assign g_if.wr      = lvl ? we_g_now : cap_wg;
   assign g_if.waddr   = lvl ? wa_g_now : cap_ga;
   assign g_if.wdata   = lvl ? wd_g_now : cap_dg;
   assign g_if.raddr   = (split | dual) ? ga_s : fa_s;
   assign g_if.ld      = bus_wr & sel_lutg;
   assign g_if.ld_data = (g_if.contents & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);

   lcs_lut #(.AW(4)) u_lut_f
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .p        (f_if.lut)
   );

   lcs_lut #(.AW(4)) u_lut_g
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .p        (g_if.lut)
   );

   // ---------------- function generator outputs ----------------
   logic       f_rd;
   logic       g_rd;
   logic       h_rd;
   logic       h0;
   logic       h2;
   logic [7:0] htab;

   assign f_rd = wide ? (d1 ? g_if.rdata : f_if.rdata) : f_if.rdata;
   assign g_rd = g_if.rdata;
   assign h0   = cfg[lcs_pkg::CFG_H0G] ? g_rd : sr_h0;
   assign h2   = cfg[lcs_pkg::CFG_H2F] ? f_rd : din;
   assign htab = map[lcs_pkg::MAP_HTAB +: 8];
   assign h_rd = htab[{h2, h1i, h0}];

   assign f_gen_out = f_rd;
   assign g_gen_out = g_rd;
   assign h_gen_out = h_rd;

   // ---------------- global force ----------------
   logic pwr_up;
   logic gsr_src;
   logic force_g;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         pwr_up <= 1'b1;
      else
         pwr_up <= 1'b0;
   end

   assign gsr_src = cfg[lcs_pkg::CFG_GPIN] ? (gpin_s ^ cfg[lcs_pkg::CFG_GINV]) : cmd[0];
   assign force_g = gsr_src | pwr_up;

   // ---------------- storage elements ----------------
   logic [1:0] q_e;
   logic [1:0] reg_out;
   logic [3:0] dsrc;

   assign dsrc = {din, h_rd, g_rd, f_rd};

   genvar e;
   generate
      for (e = 0; e < 2; e++)
      begin : g_elem
         logic edge_en;
         logic ce_e;
         logic d_e;
         logic [1:0] dsel;
         logic [1:0] bsrc;

         assign edge_en = cfg[lcs_pkg::CFG_KFALL + e] ? k_fall : k_rise;
         assign ce_e    = cfg[lcs_pkg::CFG_ECOFF + e] | ec;
         assign dsel    = cfg[lcs_pkg::CFG_DSEL + 2*e +: 2];
         assign d_e     = dsrc[dsel];
         assign bsrc    = cfg[lcs_pkg::CFG_BSRC + 2*e +: 2];
         assign reg_out[e] = cfg[lcs_pkg::CFG_BYP + e] ? cin_s[bsrc] : q_e[e];

         lcs_store u_store
         (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .edge_en  (edge_en),
            .ce       (ce_e),
            .d        (d_e),
            .init_val (cfg[lcs_pkg::CFG_INIT + e]),
            .force_g  (force_g),
            .force_l  (local_sr & cfg[lcs_pkg::CFG_SREN + e]),
            .q        (q_e[e])
         );
      end
   endgenerate

   assign registered_out_x = reg_out[0];
   assign registered_out_y = reg_out[1];

   assign status = {24'h000000, h_rd, g_rd, f_rd, lvl, q_e, reg_out[1], reg_out[0]};

   // ---------------- checks ----------------
   AST_PWR_INIT: assert property (@(posedge core_clk) disable iff (!rst_n)
      pwr_up |-> (q_e[0] == cfg[lcs_pkg::CFG_INIT]) && (q_e[1] == cfg[lcs_pkg::CFG_INIT + 1]))
      else $error("elements not at configured value after reset");

   AST_GSR_BOTH: assert property (@(posedge core_clk) disable iff (!rst_n)
      gsr_src |-> (q_e[0] == cfg[lcs_pkg::CFG_INIT]) && (q_e[1] == cfg[lcs_pkg::CFG_INIT + 1]))
      else $error("global force gave wrong value");

   AST_LOCAL_SR: assert property (@(posedge core_clk) disable iff (!rst_n)
      (local_sr && cfg[lcs_pkg::CFG_SREN]) [*2] |-> q_e[0] == cfg[lcs_pkg::CFG_INIT])
      else $error("local force did not hold element");

   AST_EDGE_WR: assert property (@(posedge core_clk) disable iff (!rst_n)
      (wclk_edge && !lvl && we_f_now) |=> f_if.wr && (f_if.waddr == $past(fa_s)))
      else $error("edge write not issued one cycle after edge");

   AST_WE_ONLY: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!lvl && !$past(lvl) && f_if.wr) |-> $past(wclk_edge && we_f_now))
      else $error("edge write without enable at edge");

   AST_LEVEL: assert property (@(posedge core_clk) disable iff (!rst_n)
      (lvl && we_g_now) |-> g_if.wr && (g_if.waddr == wa_g_now))
      else $error("level write not following strobe");

   AST_DUAL: assert property (@(posedge core_clk) disable iff (!rst_n)
      (dual && f_if.wr) |-> g_if.wr && (g_if.waddr == f_if.waddr) && !lvl)
      else $error("dual-port write not to both tables");

   AST_DUAL_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
      dual |-> (g_gen_out == g_if.contents[ga_s]) && (f_gen_out == f_if.contents[fa_s]))
      else $error("dual-port read output wrong");
endmodule
`default_nettype wire

// ===== design/lcs_lut.sv
`timescale 1ns/10ps
`default_nettype none
module lcs_lut #(parameter int AW = 4)
(
   input wire logic  core_clk,
   input wire logic  rst_n,
   lcs_lut_if.lut    p
);
   localparam int DEPTH = 1 << AW;
   logic mem [DEPTH];

   genvar i;
   generate
      for (i = 0; i < DEPTH; i++)
      begin : g_cell
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
               mem[i] <= 1'b0;
            else if (p.ld)
               mem[i] <= p.ld_data[i];
            else if (p.wr && p.waddr == AW'(i))
               mem[i] <= p.wdata;
         end
         assign p.contents[i] = mem[i];
      end
   endgenerate

   // read is a pure lookup, no clock
   assign p.rdata = mem[p.raddr];

   AST_WRITE_LANDS: assert property (@(posedge core_clk) disable iff (!rst_n)
      (p.wr && !p.ld) |=> p.contents[$past(p.waddr)] == $past(p.wdata))
      else $error("memory write did not land");
endmodule
`default_nettype wire

// ===== design/lcs_lut_if.sv
`timescale 1ns/10ps
`default_nettype none
interface lcs_lut_if #(parameter int AW = 4);
   logic                wr;
   logic [AW-1:0]       waddr;
   logic                wdata;
   logic [AW-1:0]       raddr;
   logic                rdata;
   logic                ld;
   logic [(1<<AW)-1:0]  ld_data;
   logic [(1<<AW)-1:0]  contents;
   modport ctl (output wr, waddr, wdata, raddr, ld, ld_data, input rdata, contents);
   modport lut (input wr, waddr, wdata, raddr, ld, ld_data, output rdata, contents);
endinterface
`default_nettype wire

// ===== design/lcs_pkg.sv
`default_nettype none
package lcs_pkg;
   // register byte offsets
   localparam logic [4:0] OFS_CFG  = 5'h00;
   localparam logic [4:0] OFS_MAP  = 5'h04;
   localparam logic [4:0] OFS_CMD  = 5'h08;
   localparam logic [4:0] OFS_LUTF = 5'h0C;
   localparam logic [4:0] OFS_LUTG = 5'h10;
   localparam logic [4:0] OFS_STAT = 5'h14;
   // cell configuration word fields
   localparam int CFG_MODE   = 0;
   localparam int CFG_LVL    = 2;
   localparam int CFG_WFALL  = 3;
   localparam int CFG_KFALL  = 4;
   localparam int CFG_INIT   = 6;
   localparam int CFG_SREN   = 8;
   localparam int CFG_ECOFF  = 10;
   localparam int CFG_GPIN   = 12;
   localparam int CFG_GINV   = 13;
   localparam int CFG_H0G    = 14;
   localparam int CFG_H2F    = 15;
   localparam int CFG_DSEL   = 16;
   localparam int CFG_BYP    = 20;
   localparam int CFG_BSRC   = 22;
   localparam int CFG_MEMF   = 26;
   localparam int CFG_MEMG   = 27;
   // control map word fields
   localparam int MAP_SEL    = 0;
   localparam int MAP_HTAB   = 8;
   // reset values
   localparam logic [31:0] CFG_RST  = 32'h0000_0000;
   localparam logic [31:0] MAP_RST  = 32'h0000_00E4;
   localparam logic [31:0] CMD_RST  = 32'h0000_0000;
   // internal control signal indices
   localparam int CI_EC   = 0;
   localparam int CI_SR   = 1;
   localparam int CI_DIN  = 2;
   localparam int CI_H1   = 3;
   // storage data source codes
   localparam logic [1:0] DS_F   = 2'h0;
   localparam logic [1:0] DS_G   = 2'h1;
   localparam logic [1:0] DS_H   = 2'h2;
   localparam logic [1:0] DS_DIN = 2'h3;
   typedef enum logic [1:0]
   {
      LCS_LOGIC = 2'h0,
      LCS_SPLIT = 2'h1,
      LCS_DUAL  = 2'h3,
      LCS_WIDE  = 2'h2
   } lcs_mode_t;
endpackage
`default_nettype wire

// ===== design/lcs_store.sv
`timescale 1ns/10ps
`default_nettype none
module lcs_store
(
   input wire logic  core_clk,
   input wire logic  rst_n,
   input wire logic  edge_en,
   input wire logic  ce,
   input wire logic  d,
   input wire logic  init_val,
   input wire logic  force_g,
   input wire logic  force_l,
   output logic      q
);
   logic q_reg;
   logic force_any;

   assign force_any = force_g | force_l;
   // forcing overrides clock enable and data while held
   assign q = force_any ? init_val : q_reg;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         q_reg <= 1'b0;
      else if (force_any)
         q_reg <= init_val;
      else if (edge_en && ce)
         q_reg <= d;
   end

   AST_EC_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!ce && !force_any) |=> $stable(q_reg))
      else $error("storage changed without clock enable");
endmodule
`default_nettype wire
